/* File: dv/tbi_asserts.sv */
// Concurrent checks on the two-wire link between master and target
`timescale 1ns/1ps
module tbi_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Link
  input wire logic scl,
  input wire logic m_sda_oe,
  input wire logic t_sda_o,
  input wire logic t_sda_oe,
  input wire logic sda
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Line history and open transfer tracking
  logic scl_d;
  logic sda_d;
  logic open_xfer;
  logic start_ev;
  logic stop_ev;

  assign start_ev = scl && scl_d && sda_d && !sda;
  assign stop_ev  = scl && scl_d && !sda_d && sda;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      open_xfer <= 1'b0;
    end else if (start_ev) begin
      open_xfer <= 1'b1;
    end else if (stop_ev) begin
      open_xfer <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions
  a_tgt_never_high: assert property (t_sda_oe |-> t_sda_o == 1'b0 && open_xfer)
    else $error("target drives data high or outside a transfer");
  a_oe_scl_low: assert property ($changed(t_sda_oe) |-> !scl && !$past(scl))
    else $error("target data changed outside clock low");
  a_tgt_stable_hi: assert property ($rose(scl) |-> ##1 $stable(t_sda_oe) [*8])
    else $error("target data moved while clock high");
  a_ack_low_pulse: assert property (t_sda_oe && scl |=> t_sda_oe)
    else $error("target released data while clock high");
  a_no_contention: assert property (m_sda_oe && t_sda_oe |-> !scl)
    else $error("both ends pull data during clock high");
  a_start_by_master: assert property (start_ev |-> m_sda_oe && !t_sda_oe)
    else $error("start not made by master");
  a_stop_by_master: assert property (stop_ev |-> !m_sda_oe && $past(m_sda_oe))
    else $error("stop not made by master");
  a_stop_before_start: assert property (start_ev |-> !open_xfer)
    else $error("start on an open transfer");

  // ==========================================================
  // Coverage
  c_start: cover property (start_ev);
  c_stop: cover property (stop_ev);
  c_tgt_drive: cover property ($rose(t_sda_oe) && !scl);
endmodule

/* File: dv/tbi_tb.sv */
// Self-checking bench for the master and target ends joined by the link
`timescale 1ns/1ps
module tbi_tb;
  // ==========================================================
  // Signals
  logic              clock     = 1'b0;
  logic              link_clk  = 1'b0;
  logic              nrst      = 1'b0;
  logic              cmd_valid = 1'b0;
  logic              cmd_ready;
  tbi_pkg::tbi_cmd_t cmd_kind  = tbi_pkg::TBI_CMD_START;
  logic [7:0]        cmd_data  = 8'h00;
  logic              cmd_nack  = 1'b0;
  logic              rsp_valid;
  logic [7:0]        rsp_data;
  logic              rsp_ack;
  logic              addr_sel  = 1'b0;
  logic              uvlo      = 1'b0;
  logic [7:0]        status_in = 8'h00;
  logic [7:0]        data_reg;
  logic              data_wr;
  logic [8:0]        wire_sh   = 9'h000;
  logic [8:0]        rsp_q[$];
  logic [7:0]        wr_q[$];
  int                err_count = 0;
  int                check_count = 0;
  int                cycles    = 0;
  logic [6:0]        tgt;
  logic [7:0]        d1;
  logic [7:0]        d2;
  logic [7:0]        st;
  logic              sel;

  always #5 clock = ~clock;
  always #6 link_clk = ~link_clk;

  // ==========================================================
  // Design and checker
  tbi_if bus_if();
  tbi_master tbi_master_inst (.clock(clock), .nrst(nrst), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
    .cmd_data(cmd_data), .cmd_nack(cmd_nack), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  tbi_target tbi_target_inst (.clock(clock), .nrst(nrst), .link_clk(link_clk),
    .bus(bus_if), .addr_sel(addr_sel), .uvlo(uvlo), .status_in(status_in),
    .data_reg(data_reg), .data_wr(data_wr));
  tbi_asserts tbi_asserts_inst (.clock(clock), .nrst(nrst), .scl(bus_if.scl),
    .m_sda_oe(bus_if.m_sda_oe), .t_sda_o(bus_if.t_sda_o),
    .t_sda_oe(bus_if.t_sda_oe), .sda(bus_if.sda));

  // ==========================================================
  // Tasks
  task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmd(input tbi_pkg::tbi_cmd_t k, input logic [7:0] d, input logic nk,
                     input logic [8:0] ex);
    int n;
    n = 0;
    if (k == tbi_pkg::TBI_CMD_WRITE || k == tbi_pkg::TBI_CMD_READ) rsp_q.push_back(ex);
    @(posedge clock);
    cmd_kind <= k;
    cmd_data <= d;
    cmd_nack <= nk;
    cmd_valid <= 1'b1;
    @(posedge clock);
    cmd_valid <= 1'b0;
    do begin
      @(negedge clock);
      n++;
    end while (cmd_ready !== 1'b1 && n < 3000);
    if (n >= 3000) check(9'h000, 9'h1FF, "command hang");
  endtask

  task automatic s();
    cmd(tbi_pkg::TBI_CMD_START, 8'h00, 1'b0, 9'h000);
  endtask

  task automatic p();
    cmd(tbi_pkg::TBI_CMD_STOP, 8'h00, 1'b0, 9'h000);
  endtask

  task automatic w(input logic [7:0] d, input logic a);
    cmd(tbi_pkg::TBI_CMD_WRITE, d, 1'b0, {a, d});
  endtask

  task automatic r(input logic nk, input logic [7:0] e);
    cmd(tbi_pkg::TBI_CMD_READ, 8'h00, nk, {~nk, e});
  endtask

  // ==========================================================
  // Monitors
  always @(posedge bus_if.scl) begin
    wire_sh <= {wire_sh[7:0], bus_if.sda};
  end

  always @(negedge clock) begin
    if (rsp_valid === 1'b1) begin
      if (rsp_q.size() == 0) check(9'h000, 9'h1FF, "unexpected response");
      else check({rsp_ack, rsp_data}, rsp_q.pop_front(), "response");
    end
    if (data_wr === 1'b1) begin
      if (wr_q.size() == 0) check(9'h000, 9'h1FF, "unexpected register write");
      else check({1'b0, data_reg}, {1'b0, wr_q.pop_front()}, "data register");
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 45000) begin
      err_count++;
      $display("Error at %0t: timeout", $time);
      end_of_test();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    d1 = 8'($urandom(31593));
    d2 = 8'($urandom());
    st = 8'($urandom());
    sel = 1'($urandom());
    tgt = {tbi_pkg::TBI_ADDR_HI, sel};
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    addr_sel <= sel;
    status_in <= st;
    repeat (4) @(posedge clock);
    s();
    w({tgt, 1'b0}, 1'b1);
    check(wire_sh, {tgt, 1'b0, 1'b0}, "address on wire");
    w(tbi_pkg::TBI_REG_STATUS, 1'b1);
    w(d1, 1'b1);
    wr_q.push_back(d2);
    w(d2, 1'b1);
    p();
    check({7'h00, bus_if.scl, bus_if.sda}, 9'h003, "idle bus");
    $display("Test write done");
    s();
    w({tgt, 1'b0}, 1'b1);
    w(tbi_pkg::TBI_REG_STATUS, 1'b1);
    p();
    s();
    w({tgt, 1'b1}, 1'b1);
    r(1'b0, st);
    r(1'b1, d2);
    p();
    $display("Test read done");
    @(posedge clock);
    uvlo <= 1'b1;
    s();
    w({tgt, 1'b0}, 1'b0);
    p();
    @(posedge clock);
    uvlo <= 1'b0;
    addr_sel <= ~sel;
    $display("Test undervoltage done");
    s();
    s();
    w({tgt, 1'b0}, 1'b0);
    w(tbi_pkg::TBI_REG_DATA, 1'b0);
    w(~d2, 1'b0);
    p();
    check({1'b0, data_reg}, {1'b0, d2}, "data kept");
    check(9'(rsp_q.size() + wr_q.size()), 9'h000, "pending results");
    $display("Test foreign address done");
    end_of_test();
  end
endmodule

/* File: shared/tbi_if.sv */
// Two-wire link between master and target with resolved open-drain data line
`timescale 1ns/1ps
interface tbi_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic t_sda_o;
  logic t_sda_oe;
  logic sda;

  // ==========================================================
  // Pull-up resolution of the shared data line
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (t_sda_oe ? t_sda_o : 1'b1);

  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport target (input scl, input sda, output t_sda_o, output t_sda_oe);
endinterface

/* File: shared/tbi_pkg.sv */
// Shared constants and types for the two-wire target bus interface
package tbi_pkg;
  // ==========================================================
  // Timing
  localparam int TBI_CLK_HZ  = 100_000_000;
  localparam int TBI_SCL_HZ  = 400_000;
  localparam int TBI_QTR_CYC = TBI_CLK_HZ / (4 * TBI_SCL_HZ);
  localparam logic [8:0] TBI_QTR_LAST = 9'(TBI_QTR_CYC - 1);
  // ==========================================================
  // Framing
  localparam logic [3:0] TBI_BYTE_BITS = 4'h8;
  localparam logic [3:0] TBI_LAST_BIT  = 4'h7;
  // ==========================================================
  // Target address and register map
  localparam logic [5:0] TBI_ADDR_HI    = 6'h04;
  localparam logic [7:0] TBI_REG_STATUS = 8'h00;
  localparam logic [7:0] TBI_REG_DATA   = 8'h01;
  localparam logic [7:0] TBI_DATA_RST   = 8'h00;
  // ==========================================================
  // Master commands
  typedef enum logic [1:0] {
    TBI_CMD_START,
    TBI_CMD_STOP,
    TBI_CMD_WRITE,
    TBI_CMD_READ
  } tbi_cmd_t;
endpackage

/* File: src/tbi_master.sv */
// Two-wire bus master end driving the clock and sharing the data line
`timescale 1ns/1ps
module tbi_master (
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            nrst,
  // Link
  tbi_if.master                bus,
  // Command port
  input  wire logic            cmd_valid,
  output logic                 cmd_ready,
  input  tbi_pkg::tbi_cmd_t    cmd_kind,
  input  wire logic [7:0]      cmd_data,
  input  wire logic            cmd_nack,
  // Response port
  output logic                 rsp_valid,
  output logic      [7:0]      rsp_data,
  output logic                 rsp_ack
);
  typedef enum logic {TBI_M_IDLE, TBI_M_BUSY} tbi_mst_state_t;

  tbi_mst_state_t    state;
  tbi_pkg::tbi_cmd_t op;
  logic [8:0]        tick;
  logic [1:0]        qtr;
  logic [3:0]        bitn;
  logic [7:0]        sh;
  logic              nack;
  logic              ack;
  logic              open;
  logic              pend_start;
  logic              scl;
  logic              oe;
  logic              sda_s1;
  logic              sda_s2;
  logic              qend;

  assign cmd_ready    = (state == TBI_M_IDLE);
  assign qend         = (tick == tbi_pkg::TBI_QTR_LAST);
  assign bus.scl      = scl;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = oe;

  // ==========================================================
  // Data line synchroniser
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
    end
  end

  // ==========================================================
  // Quarter period divider
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick <= 9'h000;
    end else if (state == TBI_M_IDLE || qend) begin
      tick <= 9'h000;
    end else begin
      tick <= tick + 9'h001;
    end
  end

  // ==========================================================
  // Sequencer: each step is four quarters, data moves in quarter 0
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state      <= TBI_M_IDLE;
      op         <= tbi_pkg::TBI_CMD_STOP;
      qtr        <= 2'h0;
      bitn       <= 4'h0;
      sh         <= 8'h00;
      nack       <= 1'b0;
      ack        <= 1'b0;
      open       <= 1'b0;
      pend_start <= 1'b0;
      scl        <= 1'b1;
      oe         <= 1'b0;
      rsp_valid  <= 1'b0;
      rsp_data   <= 8'h00;
      rsp_ack    <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      unique case (state)
        TBI_M_IDLE: begin
          if (cmd_valid) begin
            state <= TBI_M_BUSY;
            qtr   <= 2'h0;
            bitn  <= 4'h0;
            sh    <= cmd_data;
            nack  <= cmd_nack;
            // Close an open transfer before a new start [RL5]
            if (cmd_kind == tbi_pkg::TBI_CMD_START && open) begin
              op         <= tbi_pkg::TBI_CMD_STOP;
              pend_start <= 1'b1;
            end else begin
              op <= cmd_kind;
            end
          end
        end
        TBI_M_BUSY: begin
          if (qend) begin
            qtr <= qtr + 2'h1;
            unique case (op)
              tbi_pkg::TBI_CMD_START: begin
                unique case (qtr)
                  2'h0: oe <= 1'b0;
                  2'h1: scl <= 1'b1;
                  2'h2: oe <= 1'b1; // Falling data with clock high [RL3]
                  2'h3: begin
                    scl   <= 1'b0;
                    open  <= 1'b1;
                    state <= TBI_M_IDLE;
                  end
                endcase
              end
              tbi_pkg::TBI_CMD_STOP: begin
                unique case (qtr)
                  2'h0: oe <= 1'b1;
                  2'h1: scl <= 1'b1;
                  2'h2: oe <= 1'b0; // Rising data with clock high [RL4]
                  2'h3: begin
                    open <= 1'b0;
                    if (pend_start) begin
                      pend_start <= 1'b0;
                      op         <= tbi_pkg::TBI_CMD_START;
                    end else begin
                      state <= TBI_M_IDLE;
                    end
                  end
                endcase
              end
              default: begin
                unique case (qtr)
                  2'h0: begin
                    // Data changes only in the clock low phase [RL1] [RL2]
                    if (bitn != tbi_pkg::TBI_BYTE_BITS) begin
                      oe <= (op == tbi_pkg::TBI_CMD_WRITE) ? ~sh[7] : 1'b0; // [RL8]
                    end else if (op == tbi_pkg::TBI_CMD_WRITE) begin
                      oe <= 1'b0; // Release during the target's acknowledge [RL9]
                    end else begin
                      oe <= ~nack; // Leave high on the last read byte [RL16] [RL17]
                    end
                  end
                  2'h1: scl <= 1'b1;
                  2'h2: begin
                    if (bitn != tbi_pkg::TBI_BYTE_BITS) begin
                      sh <= {sh[6:0], sda_s2};
                    end else begin
                      ack <= ~sda_s2; // Reported so the user may abort [RL12]
                    end
                  end
                  2'h3: begin
                    scl  <= 1'b0;
                    bitn <= bitn + 4'h1;
                    // Eight data bits then one acknowledge slot [RL6] [RL7]
                    if (bitn == tbi_pkg::TBI_BYTE_BITS) begin
                      state     <= TBI_M_IDLE;
                      rsp_valid <= 1'b1;
                      rsp_data  <= sh;
                      rsp_ack   <= ack;
                    end
                  end
                endcase
              end
            endcase
          end
        end
      endcase
    end
  end
endmodule

/* File: src/tbi_target.sv */
// Two-wire target end: framing, addressing, acknowledge and register access
// How it works
// RL1: Data held steady while clock high
// RL2: Data changes only while clock low
// RL3: Data falling with clock high is start
// RL4: Data rising with clock high is stop
// RL5: Master sends stop before each start
// RL6: Each byte is exactly eight bits
// RL7: One acknowledge slot follows every byte
// RL8: Bits travel most significant first
// RL9: Master releases data during target acknowledge
// RL10: Acknowledge holds data low whole pulse
// RL11: Addressed target acknowledges each received byte
// RL12: Master may stop after missing acknowledge
// RL13: No acknowledge while undervoltage lockout active
// RL14: Address select input picks one address
// RL15: Write: address, register, data, stop
// RL16: Read continues while master acknowledges low
// RL17: Master ends read with high acknowledge
// RL18: Never drive data high, release otherwise
// RL19: Foreign address ignored until next start
`timescale 1ns/1ps
module tbi_target (
  // Clocks and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       link_clk,
  // Link
  tbi_if.target           bus,
  // User side
  input  wire logic       addr_sel,
  input  wire logic       uvlo,
  input  wire logic [7:0] status_in,
  output logic      [7:0] data_reg,
  output logic            data_wr
);
  typedef enum logic [2:0] {
    TBI_T_IDLE,
    TBI_T_RX,
    TBI_T_ACK,
    TBI_T_TX,
    TBI_T_MACK,
    TBI_T_SKIP
  } tbi_tgt_state_t;

  typedef enum logic [1:0] {TBI_K_ADDR, TBI_K_REG, TBI_K_DATA} tbi_kind_t;

  tbi_tgt_state_t state;
  tbi_kind_t      kind;
  logic [3:0]     cnt;
  logic [7:0]     sh;
  logic [7:0]     ptr;
  logic [7:0]     dreg;
  logic [7:0]     nxt_byte;
  logic [7:0]     cur_byte;
  logic           rw;
  logic           mack;
  logic           oe;
  logic           wr_tog;
  logic           scl_s1, scl_s2, scl_s3;
  logic           sda_s1, sda_s2, sda_s3;
  logic           uv_s1, uv_s2;
  logic           sel_s1, sel_s2;
  logic [7:0]     st_s1, st_s2;
  logic           tog_s1, tog_s2, tog_s3;
  logic           scl_rise, scl_fall, start, stop;

  // ==========================================================
  // Register read mux
  function automatic logic [7:0] reg_read(input logic [7:0] idx, input logic [7:0] st,
                                          input logic [7:0] dr);
    logic [7:0] val;
    val = 8'h00;
    if (idx == tbi_pkg::TBI_REG_STATUS) begin
      val = st;
    end else if (idx == tbi_pkg::TBI_REG_DATA) begin
      val = dr;
    end
    return val;
  endfunction

  // ==========================================================
  // Link side synchronisers
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      uv_s1  <= 1'b0;
      uv_s2  <= 1'b0;
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
      st_s1  <= 8'h00;
      st_s2  <= 8'h00;
    end else begin
      scl_s1 <= bus.scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      uv_s1  <= uvlo;
      uv_s2  <= uv_s1;
      sel_s1 <= addr_sel;
      sel_s2 <= sel_s1;
      st_s1  <= status_in;
      st_s2  <= st_s1;
    end
  end

  // ==========================================================
  // Line events
  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign start    = scl_s2 & scl_s3 & ~sda_s2 & sda_s3; // [RL3]
  assign stop     = scl_s2 & scl_s3 & sda_s2 & ~sda_s3; // [RL4]
  assign nxt_byte = reg_read(ptr + 8'h01, st_s2, dreg);
  assign cur_byte = reg_read(ptr, st_s2, dreg);

  // Open drain only: output level is always low [RL18]
  assign bus.t_sda_o  = 1'b0;
  assign bus.t_sda_oe = oe;

  // ==========================================================
  // Protocol engine
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      state  <= TBI_T_IDLE;
      kind   <= TBI_K_ADDR;
      cnt    <= 4'h0;
      sh     <= 8'h00;
      ptr    <= 8'h00;
      dreg   <= tbi_pkg::TBI_DATA_RST;
      rw     <= 1'b0;
      mack   <= 1'b0;
      oe     <= 1'b0;
      wr_tog <= 1'b0;
    end else if (start) begin
      state <= TBI_T_RX; // Repeated start also accepted [RL5]
      kind  <= TBI_K_ADDR;
      cnt   <= 4'h0;
      oe    <= 1'b0;
    end else if (stop) begin
      state <= TBI_T_IDLE;
      oe    <= 1'b0;
    end else begin
      unique case (state)
        TBI_T_IDLE, TBI_T_SKIP: begin
          oe <= 1'b0; // Foreign or aborted transfer stays silent [RL19]
        end
        TBI_T_RX: begin
          if (scl_rise && cnt != tbi_pkg::TBI_BYTE_BITS) begin
            sh  <= {sh[6:0], sda_s2}; // Sampled with clock high [RL1] [RL8]
            cnt <= cnt + 4'h1;        // [RL6]
          end else if (scl_fall && cnt == tbi_pkg::TBI_BYTE_BITS) begin
            // Acknowledge decision in the clock low phase [RL2] [RL7] [RL11]
            state <= TBI_T_ACK;
            cnt   <= 4'h0;
            if (uv_s2) begin
              state <= TBI_T_SKIP; // [RL13]
            end else begin
              unique case (kind)
                TBI_K_ADDR: begin
                  rw   <= sh[0];
                  kind <= TBI_K_REG;
                  if (sh[7:1] == {tbi_pkg::TBI_ADDR_HI, sel_s2}) begin // [RL14]
                    oe <= 1'b1;
                  end else begin
                    state <= TBI_T_SKIP; // [RL19]
                  end
                end
                TBI_K_REG: begin
                  ptr  <= sh; // [RL15]
                  kind <= TBI_K_DATA;
                  oe   <= 1'b1;
                end
                default: begin
                  if (ptr == tbi_pkg::TBI_REG_DATA) begin
                    dreg   <= sh; // [RL15]
                    wr_tog <= ~wr_tog;
                  end
                  ptr <= ptr + 8'h01;
                  oe  <= 1'b1;
                end
              endcase
            end
          end
        end
        TBI_T_ACK: begin
          // Low held until the acknowledge pulse ends [RL10]
          if (scl_fall) begin
            if (rw) begin
              sh    <= cur_byte; // [RL16]
              oe    <= ~cur_byte[7];
              state <= TBI_T_TX;
            end else begin
              oe    <= 1'b0;
              state <= TBI_T_RX;
            end
          end
        end
        TBI_T_TX: begin
          if (scl_fall) begin
            if (cnt == tbi_pkg::TBI_LAST_BIT) begin
              oe    <= 1'b0; // Release for the master's acknowledge [RL7]
              mack  <= 1'b0;
              state <= TBI_T_MACK;
            end else begin
              sh  <= {sh[6:0], 1'b0};
              oe  <= ~sh[6]; // Next bit, most significant first [RL8] [RL18]
              cnt <= cnt + 4'h1;
            end
          end
        end
        TBI_T_MACK: begin
          if (scl_rise) begin
            mack <= ~sda_s2;
          end else if (scl_fall) begin
            cnt <= 4'h0;
            if (mack) begin
              ptr   <= ptr + 8'h01; // Low acknowledge moves on [RL16]
              sh    <= nxt_byte;
              oe    <= ~nxt_byte[7];
              state <= TBI_T_TX;
            end else begin
              state <= TBI_T_SKIP; // High acknowledge ends the read [RL17]
            end
          end
        end
        default: begin
          state <= TBI_T_IDLE;
          oe    <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Written data handed to the user clock by toggle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tog_s1   <= 1'b0;
      tog_s2   <= 1'b0;
      tog_s3   <= 1'b0;
      data_reg <= tbi_pkg::TBI_DATA_RST;
      data_wr  <= 1'b0;
    end else begin
      tog_s1  <= wr_tog;
      tog_s2  <= tog_s1;
      tog_s3  <= tog_s2;
      data_wr <= tog_s2 ^ tog_s3;
      if (tog_s2 ^ tog_s3) begin
        data_reg <= dreg;
      end
    end
  end
endmodule
